// ---- design/gpf_port.v ----
`timescale 1ns/100ps
`include "gpf_defs.vh"
// Behaviour
// - Eight pins, each configurable as input or output; pins 0, 1, 2, 4 and 7 also as alternate function.
// - Each pin owns one function, one direction and one data bit.
// - Control and data bits sit in upstream port configuration space.
// - Function 1 gives alternate; else direction 0 input, 1 output.
// - After reset all pins are inputs, function and direction cleared.
// - Inputs sampled no more often than every 128 ns.
// - In general purpose mode the unused alternate function stays inactive.
// - In input mode the sampled level is captured into the data bit.
// - Data bit reads return the actual pin level in every mode.
// - In output mode the pin drives the stored data bit.
// - Pin 0, 1 carry port 2, 4 resets; pin 7 the event.
// - Pin 2, 4 receive expander interrupts 0 and 2, active low.
module gpf_port (
  // Clock and reset.
  input wire clock_in,
  input wire rst_b_in,
  // Configuration space write port from the upstream port.
  input wire cfg_write_in,
  input wire [7:0] pin_function_select_in,
  input wire [7:0] pin_direction_config_in,
  input wire [7:0] pin_data_bits_in,
  // Configuration space read view.
  output reg [7:0] pin_function_select_out,
  output reg [7:0] pin_direction_config_out,
  output reg [7:0] pin_data_bits_out,
  // Alternate function sources and sinks inside the device.
  input wire downstream_port2_reset_n_in,
  input wire downstream_port4_reset_n_in,
  input wire general_event_n_in,
  output reg expander_interrupt0_in_n_out,
  output reg expander_interrupt2_in_n_out,
  // Pads.
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe_n_out
);
  reg [7:0] func_reg;
  reg [7:0] dir_reg;
  reg [7:0] out_data_reg;
  reg [7:0] sample_reg;
  reg [`GPF_SAMPLE_CNT_W-1:0] tick_reg;
  reg [7:0] alt_out_next;
  reg [7:0] alt_out_mask;
  reg [7:0] pin_next;
  reg [7:0] oe_n_next;
  wire [7:0] sync_pins;
  wire sample_now;
  integer k;

  gpf_sync u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in(pin_in),
    .sync_out(sync_pins)
  );

  // Divider spaces samples at least 128 ns apart (six 25 ns cycles).
  localparam integer TICK_LAST_INT = `GPF_SAMPLE_CYCLES - 1;
  localparam [`GPF_SAMPLE_CNT_W-1:0] TICK_LAST =
    TICK_LAST_INT[`GPF_SAMPLE_CNT_W-1:0];
  assign sample_now = (tick_reg == TICK_LAST);

  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      tick_reg <= {`GPF_SAMPLE_CNT_W{1'b0}};
    end else if (sample_now) begin
      tick_reg <= {`GPF_SAMPLE_CNT_W{1'b0}};
    end else begin
      tick_reg <= tick_reg + 3'h1;
    end
  end

  // Control bits, one per pin, held in upstream configuration space.
  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      func_reg <= `GPF_FUNC_RESET;
      dir_reg <= `GPF_DIR_RESET;
      out_data_reg <= `GPF_DATA_RESET;
    end else if (cfg_write_in) begin
      func_reg <= pin_function_select_in;
      dir_reg <= pin_direction_config_in;
      out_data_reg <= pin_data_bits_in;
    end
  end

  // Sampled pin levels feed data reads in every mode.
  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      sample_reg <= `GPF_DATA_RESET;
    end else if (sample_now) begin
      sample_reg <= sync_pins;
    end
  end

  // Alternate output sources per pin; zero mask marks no alternate output.
  always @* begin
    alt_out_next = 8'hFF;
    alt_out_mask = 8'h00;
    alt_out_next[`GPF_PIN_PORT2_RESET] = downstream_port2_reset_n_in;
    alt_out_next[`GPF_PIN_PORT4_RESET] = downstream_port4_reset_n_in;
    alt_out_next[`GPF_PIN_EVENT] = general_event_n_in;
    alt_out_mask[`GPF_PIN_PORT2_RESET] = 1'b1;
    alt_out_mask[`GPF_PIN_PORT4_RESET] = 1'b1;
    alt_out_mask[`GPF_PIN_EVENT] = 1'b1;
  end

  always @* begin
    pin_next = 8'h00;
    oe_n_next = 8'hFF;
    for (k = 0; k < `GPF_PIN_COUNT; k = k + 1) begin
      if (func_reg[k]) begin
        pin_next[k] = alt_out_next[k];
        oe_n_next[k] = ~alt_out_mask[k];
      end else if (dir_reg[k]) begin
        pin_next[k] = out_data_reg[k];
        oe_n_next[k] = 1'b0;
      end else begin
        pin_next[k] = 1'b0;
        oe_n_next[k] = 1'b1;
      end
    end
  end

  // Pad drive is registered; board logic sees it as asynchronous anyway.
  always @(posedge clock_in) begin
    if (!rst_b_in) begin
      pin_out <= 8'h00;
      pin_oe_n_out <= 8'hFF;
      expander_interrupt0_in_n_out <= 1'b1;
      expander_interrupt2_in_n_out <= 1'b1;
      pin_function_select_out <= `GPF_FUNC_RESET;
      pin_direction_config_out <= `GPF_DIR_RESET;
      pin_data_bits_out <= `GPF_DATA_RESET;
    end else begin
      pin_out <= pin_next;
      pin_oe_n_out <= oe_n_next;
      // Interrupts read inactive (high) unless the pin is in alternate mode.
      expander_interrupt0_in_n_out <= func_reg[`GPF_PIN_EXP_INT0] ?
        sample_reg[`GPF_PIN_EXP_INT0] : 1'b1;
      expander_interrupt2_in_n_out <= func_reg[`GPF_PIN_EXP_INT2] ?
        sample_reg[`GPF_PIN_EXP_INT2] : 1'b1;
      pin_function_select_out <= func_reg;
      pin_direction_config_out <= dir_reg;
      pin_data_bits_out <= sample_reg;
    end
  end
endmodule // gpf_port

// ---- design/gpf_defs.vh ----
`ifndef GPF_DEFS_VH
`define GPF_DEFS_VH
`define GPF_PIN_COUNT 8
`define GPF_PIN_PORT2_RESET 0
`define GPF_PIN_PORT4_RESET 1
`define GPF_PIN_EXP_INT0 2
`define GPF_PIN_EXP_INT2 4
`define GPF_PIN_EVENT 7
`define GPF_FUNC_RESET 8'h00
`define GPF_DIR_RESET 8'h00
`define GPF_DATA_RESET 8'h00
`define GPF_CLOCK_NS 25
`define GPF_SAMPLE_NS 128
`define GPF_SAMPLE_CYCLES ((`GPF_SAMPLE_NS + `GPF_CLOCK_NS - 1) / `GPF_CLOCK_NS)
`define GPF_SAMPLE_CNT_W 3
`endif

// ---- design/gpf_sync.v ----
`timescale 1ns/100ps
`include "gpf_defs.vh"
module gpf_sync (
  // Clock and reset.
  input wire clock_in,
  input wire rst_b_in,
  // Raw pin levels and synchronised result.
  input wire [7:0] async_in,
  output wire [7:0] sync_out
);
  reg [7:0] stage1_reg;
  reg [7:0] stage2_reg;
  genvar i;
  generate
    for (i = 0; i < `GPF_PIN_COUNT; i = i + 1) begin : g_bit
      always @(posedge clock_in) begin
        if (!rst_b_in) begin
          stage1_reg[i] <= 1'b0;
          stage2_reg[i] <= 1'b0;
        end else begin
          stage1_reg[i] <= async_in[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate
  assign sync_out = stage2_reg;
endmodule // gpf_sync

// ---- sim/gpf_port_asserts.sv ----
`timescale 1ns/100ps
module gpf_port_asserts (
  input logic clock_in, rst_b_in, cfg_write_in, general_event_n_in,
  input logic expander_interrupt0_in_n_out, expander_interrupt2_in_n_out,
  input logic [7:0] pin_data_bits_in, pin_function_select_out,
  input logic [7:0] pin_direction_config_out, pin_data_bits_out,
  input logic [7:0] pin_in, pin_out, pin_oe_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  chk_reset_idle: assert property (
    $rose(rst_b_in) |-> pin_oe_n_out == 8'hFF) else $error("reset");
  chk_mode_drive: assert property (
    cfg_write_in |-> ##2 pin_oe_n_out == ~(~pin_function_select_out &
    pin_direction_config_out | pin_function_select_out & 8'h83))
    else $error("enable");
  chk_out_data: assert property (
    cfg_write_in |-> ##2 ((pin_out ^ $past(pin_data_bits_in, 2)) &
    ~pin_function_select_out & pin_direction_config_out) == 8'h00)
    else $error("drive");
  chk_event_alt: assert property (
    pin_function_select_out[7] && $past(pin_function_select_out[7]) |->
    pin_out[7] == $past(general_event_n_in)) else $error("event");
  chk_int_idle: assert property (
    !pin_function_select_out[2] && !$past(pin_function_select_out[2]) |->
    expander_interrupt0_in_n_out) else $error("idle");
  chk_int_follow: assert property (
    (pin_function_select_out[4] && $stable(pin_in[4]))[*8] ##1
    (pin_function_select_out[4] && $stable(pin_in[4]))[*2] |->
    expander_interrupt2_in_n_out == pin_in[4]) else $error("int");
  chk_data_follow: assert property (
    $stable(pin_in)[*8] ##1 $stable(pin_in)[*2] |->
    pin_data_bits_out == pin_in) else $error("data");
  chk_sample_gap: assert property (
    $changed(pin_data_bits_out) |=> $stable(pin_data_bits_out)[*5])
    else $error("gap");
  cover property (cfg_write_in);
  cover property (!expander_interrupt2_in_n_out);
  cover property ($changed(pin_data_bits_out));
endmodule // gpf_port_asserts
bind gpf_port gpf_port_asserts gpf_chk_inst (.*);

// ---- sim/gpf_board.sv ----
`timescale 1ns/100ps
module gpf_board (
  input logic [7:0] pin_out, pin_oe_n_out, board_level_in,
  output logic [7:0] pin_in
);
  // No board clock samples the outputs, so their edges may land anywhere.
  assign pin_in = pin_out & ~pin_oe_n_out |
    board_level_in & pin_oe_n_out;
endmodule // gpf_board

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic clock_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0;
  logic p2 = 1'b1, p4 = 1'b1, ev = 1'b1;
  logic [7:0] fs = 8'h00, dc = 8'h00, db = 8'h00, lvl = 8'h00;
  logic [7:0] g, alt, drv, val;
  logic [31:0] seed = 32'hB5D5;
  wire [7:0] fo, dco, dbo, po, oen, pin;
  wire i0, i2;
  int errors = 0, n_compared = 0;
  gpf_port gpf_port_inst (.clock_in(clock_in), .rst_b_in(rst_b_in),
    .cfg_write_in(wr), .pin_function_select_in(fs),
    .pin_direction_config_in(dc), .pin_data_bits_in(db),
    .pin_function_select_out(fo), .pin_direction_config_out(dco),
    .pin_data_bits_out(dbo), .downstream_port2_reset_n_in(p2),
    .downstream_port4_reset_n_in(p4), .general_event_n_in(ev),
    .expander_interrupt0_in_n_out(i0), .expander_interrupt2_in_n_out(i2),
    .pin_in(pin), .pin_out(po), .pin_oe_n_out(oen));
  gpf_board gpf_board_inst (.pin_out(po), .pin_oe_n_out(oen),
    .board_level_in(lvl), .pin_in(pin));
  function automatic [31:0] lfsr(input [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always #12.5 clock_in = ~clock_in;
  initial begin
    #25000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clock_in);
    check(oen, 8'hFF);
    check(fo | dco | po, 8'h00);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      wr <= 1'b1;
      fs <= i == 0 ? 8'hFF : i == 1 ? 8'h00 : seed[7:0];
      dc <= i == 1 ? 8'hFF : seed[15:8];
      db <= seed[23:16];
      lvl <= seed[31:24];
      {p2, p4, ev} <= seed[2:0];
      @(posedge clock_in);
      wr <= 1'b0;
      // Twelve cycles cover the worst input sampling latency.
      repeat (12) @(posedge clock_in);
      g = ~fs & dc;
      alt = fs & 8'h83;
      drv = g | alt;
      val = g & db | alt & {ev, 5'h00, p4, p2};
      check(oen, ~drv);
      check(po & drv, val);
      check(dbo, val | lvl & ~drv);
      check({6'h00, i2, i0}, {6'h00, ~fs[4] | lvl[4], ~fs[2] | lvl[2]});
    end
    report_and_stop();
  end
endmodule // tb
